// [hdl/drsq_pkg.sv]
// Purpose: shared constants for the dual reset power sequencer
// Assumes: 50 MHz aclk, 32-bit AXI4-Lite register bus
// Notes:   register offsets are byte addresses on the bus
package drsq_pkg;
  // =====================================================
  // clock and timing
  localparam int unsigned CLK_FREQ_HZ    = 50_000_000;  // aclk rate
  localparam int unsigned MS_PER_SEC     = 1000;        // ms in one second
  localparam int unsigned CYC_PER_MS_DEF = CLK_FREQ_HZ / MS_PER_SEC;
  localparam logic [7:0]  PLL_MS_RST     = 8'h04;       // 4 ms start-up default
  // =====================================================
  // register byte offsets
  localparam logic [7:0]  OFS_CLK_CTRL   = 8'h00;       // start-up timer, ms
  localparam logic [7:0]  OFS_MISC3      = 8'h04;       // refresh enable
  localparam logic [7:0]  OFS_GP_CTRL    = 8'h08;       // gp pin presets
  localparam logic [7:0]  OFS_STATUS     = 8'h0c;       // read-only state
  // =====================================================
  // field positions and reset values
  localparam int unsigned REFRESH_BIT    = 2;           // micro power refresh
  localparam int unsigned GPA_RUN_BIT    = 0;           // pin a in run
  localparam int unsigned GPB_RUN_BIT    = 1;           // pin b in run
  localparam int unsigned GPA_OFF_BIT    = 2;           // pin a in power off
  localparam int unsigned GPB_OFF_BIT    = 3;           // pin b in power off
  localparam logic [3:0]  GP_CTRL_RST    = 4'h0;        // all pins low
  localparam logic [1:0]  RESP_OKAY      = 2'h0;        // axi okay
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;        // axi slave error
  // sequencer states
  typedef enum logic [1:0] {
    DRSQ_HOLD,                                          // an input asserted
    DRSQ_COUNT,                                         // start-up timer runs
    DRSQ_RUN,                                           // normal operation
    DRSQ_MPOFF                                          // micro power off
  } drsq_state_t;
endpackage : drsq_pkg

// [hdl/drsq_top.sv]
// Purpose: reset sequencing for cold boot, warm reset and micro power off
// Assumes: reset inputs are active low pins from outside the aclk domain
// Notes:   aresetn stands for core supply presence
`timescale 1ns/1ps
module drsq_top import drsq_pkg::*; #(
  parameter int unsigned CYC_PER_MS = CYC_PER_MS_DEF    // cycles per ms
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // reset and supply pins
  input  wire logic        master_reset_in_n,
  input  wire logic        io_power_good_reset_in_n,
  input  wire logic        system_io_supply,
  // sequencer outputs
  output logic             system_reset_drive_out,
  output logic             pll_gate_off,
  output logic             cpu_hold,
  output logic             io_pulldown_en,
  output logic             rtc_reset,
  output logic             programmable_gp_pin_a,
  output logic             programmable_gp_pin_b,
  output logic             refresh_en,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // =====================================================
  // input synchronisers
  logic [2:0]  s1_q, s2_q, s3_q;                        // three-flop chain
  logic [2:0]  sync_q;                                  // filtered levels
  logic        m_s, io_s, system_io_supply_s;                       // high = released, or supply present

  // sample pins; level accepted once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q   <= 3'h0;
      s2_q   <= 3'h0;
      s3_q   <= 3'h0;
      sync_q <= 3'h0;
    end else begin
      s1_q <= {system_io_supply, io_power_good_reset_in_n, master_reset_in_n};
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < 3; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          sync_q[i] <= s3_q[i];
        end
      end
    end
  end
  assign m_s    = sync_q[0];
  assign io_s   = sync_q[1];
  assign system_io_supply_s = sync_q[2];

  // =====================================================
  // configuration registers
  logic [7:0]  timer_ms_q;                              // pll start-up, ms
  logic        refresh_q;                               // power off refresh
  logic [3:0]  gp_ctrl_q;                               // gp run/off values
  logic        wr_fire;                                 // write commits now
  logic [7:0]  wr_addr_q;                               // latched address
  logic [31:0] wr_data_q;                               // latched data
  logic [3:0]  wr_strb_q;                               // latched strobes

  // master reset restores defaults; power-good leaves them alone
  always_ff @(posedge aclk) begin
    if (!aresetn || !m_s) begin
      timer_ms_q <= PLL_MS_RST;
      refresh_q  <= 1'b0;
      gp_ctrl_q  <= GP_CTRL_RST;
    end else if (wr_fire && wr_strb_q[0]) begin
      case (wr_addr_q)
        OFS_CLK_CTRL: timer_ms_q <= wr_data_q[7:0];
        OFS_MISC3:    refresh_q  <= wr_data_q[REFRESH_BIT];
        OFS_GP_CTRL:  gp_ctrl_q  <= wr_data_q[3:0];
        default:      ;                                 // no storage
      endcase
    end
  end

  // =====================================================
  // ms tick divider and start-up countdown
  logic [15:0] div_q;                                   // cycles within ms
  logic        ms_tick;                                 // one-cycle enable
  logic [7:0]  ms_left_q;                               // ms still to wait
  drsq_state_t state_q, state_d;                        // sequencer state
  logic        load;                                    // countdown start

  assign ms_tick = (div_q == 16'(CYC_PER_MS - 1));
  assign load    = (state_q != DRSQ_COUNT) && (state_d == DRSQ_COUNT);

  // divider restarts with every countdown so each ms is whole
  always_ff @(posedge aclk) begin
    if (!aresetn || load || ms_tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // countdown loads the held timer value at release, or 1 when it is zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_left_q <= PLL_MS_RST;
    end else if (load) begin
      ms_left_q <= (timer_ms_q == 8'h00) ? 8'h01 : timer_ms_q;
    end else if (state_q == DRSQ_COUNT && ms_tick && ms_left_q != 8'h00) begin
      ms_left_q <= ms_left_q - 8'h01;
    end
  end

  // =====================================================
  // sequencer
  // next state from synced inputs; master reset always wins
  always_comb begin
    state_d = state_q;
    case (state_q)
      DRSQ_HOLD: begin
        if (m_s && io_s) begin
          state_d = DRSQ_COUNT;
        end
      end
      DRSQ_COUNT: begin
        if (!m_s || !io_s) begin
          state_d = DRSQ_HOLD;
        end else if (ms_left_q == 8'h00) begin
          state_d = DRSQ_RUN;
        end
      end
      DRSQ_RUN: begin
        if (!m_s) begin
          state_d = DRSQ_HOLD;
        end else if (!io_s) begin
          state_d = DRSQ_MPOFF;
        end
      end
      DRSQ_MPOFF: begin
        if (!m_s) begin
          state_d = DRSQ_HOLD;
        end else if (io_s) begin
          state_d = DRSQ_COUNT;
        end
      end
      default: state_d = DRSQ_HOLD;
    endcase
  end

  // cold boot starts in hold; no path reaches power off before run
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= DRSQ_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  // =====================================================
  // registered outputs
  logic        in_rst_d;                                // reset next cycle

  assign in_rst_d = (state_d != DRSQ_RUN);

  // reset, pll gate and cpu hold move together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_reset_drive_out <= 1'b1;
      pll_gate_off           <= 1'b1;
      cpu_hold               <= 1'b1;
    end else begin
      system_reset_drive_out <= in_rst_d;
      pll_gate_off           <= in_rst_d;
      cpu_hold               <= in_rst_d;
    end
  end

  // pull-down term decoded from the two synced inputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_pulldown_en <= 1'b1;
    end else begin
      io_pulldown_en <= !(m_s && io_s);
    end
  end

  // rtc reset follows master reset only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rtc_reset <= 1'b1;
    end else begin
      rtc_reset <= !m_s;
    end
  end

  // gp pins take their power off preset while in power off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      programmable_gp_pin_a <= 1'b0;
      programmable_gp_pin_b <= 1'b0;
      refresh_en            <= 1'b0;
    end else if (state_q == DRSQ_MPOFF) begin
      programmable_gp_pin_a <= gp_ctrl_q[GPA_OFF_BIT];
      programmable_gp_pin_b <= gp_ctrl_q[GPB_OFF_BIT];
      refresh_en            <= refresh_q;
    end else begin
      programmable_gp_pin_a <= gp_ctrl_q[GPA_RUN_BIT];
      programmable_gp_pin_b <= gp_ctrl_q[GPB_RUN_BIT];
      refresh_en            <= 1'b0;
    end
  end

  // =====================================================
  // axi4-lite slave
  logic        aw_have_q, w_have_q;                     // halves captured

  // address and data captured in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 32'h0000_0000;
      wr_strb_q <= 4'h0;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        wr_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q  <= 1'b1;
        wr_data_q <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
      end
    end
  end
  assign wr_fire       = aw_have_q && w_have_q && !s_axi_bvalid;
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;

  // write response one cycle after commit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_addr_q == OFS_CLK_CTRL || wr_addr_q == OFS_MISC3 ||
                       wr_addr_q == OFS_GP_CTRL) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read data one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        OFS_CLK_CTRL: s_axi_rdata <= {24'h000000, timer_ms_q};
        OFS_MISC3:    s_axi_rdata <= 32'(refresh_q) << REFRESH_BIT;
        OFS_GP_CTRL:  s_axi_rdata <= {28'h0000000, gp_ctrl_q};
        OFS_STATUS:   s_axi_rdata <= {16'h0000, ms_left_q, 1'b0,
                                      io_pulldown_en, system_reset_drive_out,
                                      system_io_supply_s, io_s, m_s, 2'(state_q)};
        default: begin
          s_axi_rdata <= 32'h0000_0000;                 // unmapped
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // =====================================================
  // assertions
  sequence s_both_taken;
    aw_have_q && w_have_q && !s_axi_bvalid;
  endsequence

  property p_wr_resp;
    @(posedge aclk) disable iff (!aresetn)
      s_both_taken |=> s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("no write response");

  property p_any_low_resets;
    @(posedge aclk) disable iff (!aresetn)
      (!m_s || !io_s) |=> system_reset_drive_out;
  endproperty
  a_any_low_resets: assert property (p_any_low_resets)
    else $error("reset not asserted");

  property p_defaults;
    @(posedge aclk) disable iff (!aresetn)
      !m_s |=> (timer_ms_q == PLL_MS_RST) && !refresh_q;
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("defaults not restored");

  property p_refresh_kept;
    @(posedge aclk) disable iff (!aresetn)
      (m_s && !io_s && !wr_fire) |=> $stable(refresh_q);
  endproperty
  a_refresh_kept: assert property (p_refresh_kept)
    else $error("refresh changed without master reset");

  property p_pulldown;
    @(posedge aclk) disable iff (!aresetn)
      ##1 io_pulldown_en == !($past(m_s) && $past(io_s));
  endproperty
  a_pulldown: assert property (p_pulldown)
    else $error("pull-down term wrong");

  property p_release_at_terminal;
    @(posedge aclk) disable iff (!aresetn)
      $fell(system_reset_drive_out) |->
        $past(state_q == DRSQ_COUNT && ms_left_q == 8'h00);
  endproperty
  a_release_at_terminal: assert property (p_release_at_terminal)
    else $error("reset released early");

  property p_mpoff_gated;
    @(posedge aclk) disable iff (!aresetn)
      (state_q == DRSQ_MPOFF) [*2] |->
        pll_gate_off && cpu_hold && system_reset_drive_out;
  endproperty
  a_mpoff_gated: assert property (p_mpoff_gated)
    else $error("pll not gated in power off");

  property p_gp_preset;
    @(posedge aclk) disable iff (!aresetn)
      (state_q == DRSQ_MPOFF) |=>
        programmable_gp_pin_a == $past(gp_ctrl_q[GPA_OFF_BIT]);
  endproperty
  a_gp_preset: assert property (p_gp_preset)
    else $error("gp preset not applied");

  property p_rtc_only_master;
    @(posedge aclk) disable iff (!aresetn)
      (m_s && !io_s) |=> !rtc_reset;
  endproperty
  a_rtc_only_master: assert property (p_rtc_only_master)
    else $error("rtc reset by power-good");

  property p_run_from_count;
    @(posedge aclk) disable iff (!aresetn)
      (state_q != DRSQ_RUN) ##1 (state_q == DRSQ_RUN) |->
        $past(state_q) == DRSQ_COUNT;
  endproperty
  a_run_from_count: assert property (p_run_from_count)
    else $error("run entered without countdown");
endmodule : drsq_top

// [testbench/drsq_partner.sv]
// Purpose: model of the outside reset source and primary supply
// Assumes: CYC_PER_MS matches the value given to the sequencer
// Notes:   pins change by non-blocking assignment right after an edge
`timescale 1ns/1ps
module drsq_partner #(
  parameter int unsigned CYC_PER_MS = 10    // cycles per ms
) (
  // clock
  input  wire logic aclk,
  // reset and supply pins
  output logic      master_reset_in_n,
  output logic      io_power_good_reset_in_n,
  output logic      system_io_supply
);
  // =====================================================
  // power application: everything low, both resets asserted
  initial begin
    master_reset_in_n        = 1'h0;
    io_power_good_reset_in_n = 1'h0;
    system_io_supply         = 1'h0;
  end

  // =====================================================
  // cold boot: supply up, master held one second, power-good lags
  task automatic cold_boot();
    @(posedge aclk);
    system_io_supply <= 1'h1;
    repeat (1000 * CYC_PER_MS) @(posedge aclk); // full second of master hold
    master_reset_in_n <= 1'h1;
    // one shared source, power-good settles slightly later
    repeat (100) @(posedge aclk);
    io_power_good_reset_in_n <= 1'h1;           // full high speed boot before power off
  endtask

  // =====================================================
  // warm reset: master pulse of at least 250 ms
  task automatic warm_reset();
    @(posedge aclk);
    master_reset_in_n <= 1'h0;
    repeat (250 * CYC_PER_MS) @(posedge aclk); // minimum warm pulse
    master_reset_in_n <= 1'h1;
  endtask

  // =====================================================
  // micro power off entry: power-good first, then supply drops
  task automatic off_enter();
    @(posedge aclk);
    io_power_good_reset_in_n <= 1'h0;
    repeat (10) @(posedge aclk);
    system_io_supply <= 1'h0;
  endtask

  // micro power off exit: supply returns before power-good
  task automatic off_exit();
    @(posedge aclk);
    system_io_supply <= 1'h1;
    repeat (10) @(posedge aclk);
    io_power_good_reset_in_n <= 1'h1;
  endtask
endmodule // drsq_partner

// [testbench/drsq_top_test.sv]
// Purpose: directed bench for the dual reset sequencer
// Assumes: CYC_PER_MS shortened to 10, so 1 ms is 10 cycles
// Notes:   bus waits end only through the cycle ceiling
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error t=%0t got %0h exp %0h", $time, g, e); end end
module drsq_top_test;
  import drsq_pkg::*;
  // =====================================================
  // clock, reset, pins and bus
  localparam int unsigned CPM = 10;               // cycles per ms
  logic aclk = 1'h0, aresetn = 1'h0;
  wire  master_reset_in_n, io_power_good_reset_in_n, system_io_supply;
  logic system_reset_drive_out, pll_gate_off, cpu_hold, io_pulldown_en, rtc_reset;
  logic programmable_gp_pin_a, programmable_gp_pin_b, refresh_en;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          error_cnt = 0, num_checks = 0, cyc = 0;

  // clock and cycle ceiling
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      stop_test();
    end
  end

  drsq_top #(.CYC_PER_MS(CPM)) dut_u (
    .aclk, .aresetn, .master_reset_in_n, .io_power_good_reset_in_n, .system_io_supply,
    .system_reset_drive_out, .pll_gate_off, .cpu_hold, .io_pulldown_en, .rtc_reset,
    .programmable_gp_pin_a, .programmable_gp_pin_b, .refresh_en,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  drsq_partner #(.CYC_PER_MS(CPM)) p_u (
    .aclk, .master_reset_in_n, .io_power_good_reset_in_n, .system_io_supply);

  // =====================================================
  // bus tasks: write with expected response, masked read compare
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;                            // halves already taken
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    aw_ok = 1'h0;
    w_ok  = 1'h0;
    while (!(aw_ok && w_ok)) begin
      @(negedge aclk);
      aw_ok = aw_ok || (s_axi_awvalid && s_axi_awready);
      w_ok  = w_ok || (s_axi_wvalid && s_axi_wready);
      @(posedge aclk);
      if (aw_ok) s_axi_awvalid <= 1'h0;
      if (w_ok) s_axi_wvalid <= 1'h0;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'h1);
    `CHK(s_axi_bresp, er)
    @(posedge aclk);
    s_axi_bready <= 1'h0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do @(negedge aclk); while (s_axi_arready !== 1'h1);
    @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'h1);
    `CHK(s_axi_rdata & m, e)
    `CHK(s_axi_rresp, er)
    @(posedge aclk);
    s_axi_rready <= 1'h0;
  endtask

  // reset output with the gates that follow it
  task automatic chk_rst(input logic e);
    `CHK(system_reset_drive_out, e)
    `CHK(pll_gate_off, e)
    `CHK(cpu_hold, e)
  endtask

  // cycles from the last release until reset falls must sit in a window
  task automatic fall_in(input int lo, input int hi);
    int n;
    n = 0;
    while (system_reset_drive_out === 1'h1) begin
      @(negedge aclk);
      n++;
    end
    `CHK(n >= lo && n <= hi, 1'h1)
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // =====================================================
  // main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(negedge aclk);
    chk_rst(1'h1);
    // cold boot: master released first, power-good still low
    fork
      p_u.cold_boot();
      begin
        repeat (1000 * CPM + 50) @(negedge aclk);
        chk_rst(1'h1);
        `CHK(io_pulldown_en, 1'h1)
      end
    join
    fall_in(4 * CPM, 4 * CPM + 10);
    `CHK(io_pulldown_en, 1'h0)
    `CHK(rtc_reset, 1'h0)
    $display("test cold boot done");
    rchk(OFS_CLK_CTRL, 32'hff, 32'h4, RESP_OKAY);
    rchk(OFS_MISC3, 32'h4, 32'h0, RESP_OKAY);
    rchk(8'h10, 32'hffffffff, 32'h0, RESP_SLVERR);
    wr(8'h10, 32'hff, RESP_SLVERR);
    wr(OFS_CLK_CTRL, 32'h8, RESP_OKAY);
    wr(OFS_MISC3, 32'h4, RESP_OKAY);
    wr(OFS_GP_CTRL, 32'hc, RESP_OKAY);
    rchk(OFS_STATUS, 32'h7f, 32'h1e, RESP_OKAY);
    `CHK({programmable_gp_pin_b, programmable_gp_pin_a}, 2'h0)
    $display("test registers done");
    // micro power off entry
    fork
      p_u.off_enter();
      begin
        repeat (7) @(negedge aclk);
        chk_rst(1'h1);
      end
    join
    repeat (200) @(negedge aclk);
    chk_rst(1'h1);
    `CHK(io_pulldown_en, 1'h1)
    `CHK(rtc_reset, 1'h0)
    `CHK(refresh_en, 1'h1)
    `CHK({programmable_gp_pin_b, programmable_gp_pin_a}, 2'h3)
    rchk(OFS_CLK_CTRL, 32'hff, 32'h8, RESP_OKAY);
    rchk(OFS_STATUS, 32'h3, 32'h3, RESP_OKAY);
    // micro power off exit with the preserved 8 ms timer
    fork
      p_u.off_exit();
      begin
        repeat (5) @(negedge aclk);
        chk_rst(1'h1);
      end
    join
    fall_in(8 * CPM, 8 * CPM + 10);
    rchk(OFS_MISC3, 32'h4, 32'h4, RESP_OKAY);
    `CHK({programmable_gp_pin_b, programmable_gp_pin_a}, 2'h0)
    $display("test power off done");
    // warm reset restores defaults and the 4 ms timer
    fork
      p_u.warm_reset();
      begin
        repeat (7) @(negedge aclk);
        chk_rst(1'h1);
        `CHK(io_pulldown_en, 1'h1)
        `CHK(rtc_reset, 1'h1)
      end
    join
    fall_in(4 * CPM, 4 * CPM + 10);
    rchk(OFS_CLK_CTRL, 32'hff, 32'h4, RESP_OKAY);
    rchk(OFS_MISC3, 32'h4, 32'h0, RESP_OKAY);
    rchk(OFS_GP_CTRL, 32'hf, 32'h0, RESP_OKAY);
    $display("test warm reset done");
    stop_test();
  end
endmodule // drsq_top_test
